// >>> rtl/xhv_top.v
// exposure handshake, video timing and axi4-lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "xhv_consts.vh"
module xhv_top #(
  parameter [31:0] HEALTH_CYCLES = `XHV_HEALTH_CYCLES
) (
  input wire clock,
  input wire arst_n,
  input wire ce,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pixel_clock,
  input wire beam_at_intensity,
  input wire expose_request,
  input wire [15:0] pixel_in,
  output reg pixel_take,
  output reg detector_ok_flag,
  output reg detector_armed,
  output reg expose_ok_n,
  output wire frame_exposed_tag,
  output reg rad_frame_shown,
  output reg frame_sync_n,
  output reg line_sync_n,
  output reg pixel_valid_n,
  output reg [15:0] pixel_data
);
  // ---------------------------------------------------------------
  // register select and byte-lane helpers
  // ---------------------------------------------------------------
  localparam [2:0] SEL_CTRL = 3'h0;
  localparam [2:0] SEL_STATUS = 3'h1;
  localparam [2:0] SEL_GEOM_H = 3'h2;
  localparam [2:0] SEL_GEOM_V = 3'h3;
  localparam [2:0] SEL_FRAMES = 3'h4;
  localparam [2:0] SEL_NONE = 3'h7;
  // address decode shared by the read and write paths
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      case (addr)
        `XHV_OFS_CTRL: reg_sel = SEL_CTRL;
        `XHV_OFS_STATUS: reg_sel = SEL_STATUS;
        `XHV_OFS_GEOM_H: reg_sel = SEL_GEOM_H;
        `XHV_OFS_GEOM_V: reg_sel = SEL_GEOM_V;
        `XHV_OFS_FRAMES: reg_sel = SEL_FRAMES;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction
  // merge written bytes into an old word
  function [31:0] apply_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      apply_strb = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          apply_strb[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  wire [2:0] sync_w;
  wire pclk_s, beam_s, req_s;
  // pixel clock, beam and request all arrive asynchronously
  xhv_sync #(.W(3)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .async_in({expose_request, beam_at_intensity, pixel_clock}),
    .sync_out(sync_w)
  );
  assign pclk_s = sync_w[0];
  assign beam_s = sync_w[1];
  assign req_s = sync_w[2];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [1:0] ctrl_q;
  reg [31:0] geom_h_q;
  reg [31:0] geom_v_q;
  reg [15:0] frames_q;
  reg arm_err_q;
  reg aw_full_q, w_full_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire video_en, expose_en, wr_go, arm_err_set;
  wire [2:0] wr_sel;
  wire [31:0] status_w, ctrl_wr_w;
  assign video_en = ctrl_q[`XHV_CTRL_VIDEO_EN];
  assign expose_en = ctrl_q[`XHV_CTRL_EXPOSE_EN];
  assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_sel = reg_sel(awaddr_q);
  assign ctrl_wr_w = apply_strb({30'h0, ctrl_q}, wdata_q, wstrb_q);
  // status word: live state in the low byte, sticky error above
  assign status_w = {23'h000000, arm_err_q, 3'h0, frame_exposed_tag, beam_s, req_s,
                     detector_armed, detector_ok_flag};
  // write address and data channels, taken in either order
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `XHV_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == SEL_NONE) ? `XHV_RESP_SLVERR : `XHV_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // writable registers
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `XHV_CTRL_RST;
      geom_h_q <= `XHV_GEOM_H_RST;
      geom_v_q <= `XHV_GEOM_V_RST;
    end else if (ce && wr_go) begin
      case (wr_sel)
        SEL_CTRL: ctrl_q <= ctrl_wr_w[1:0];
        SEL_GEOM_H: geom_h_q <= apply_strb(geom_h_q, wdata_q, wstrb_q) & 32'h0fff_0fff;
        SEL_GEOM_V: geom_v_q <= apply_strb(geom_v_q, wdata_q, wstrb_q) & 32'h0fff_0fff;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
  // read channel, one cycle from address to data
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `XHV_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `XHV_RESP_OKAY;
        case (reg_sel(s_axi_araddr))
          SEL_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
          SEL_STATUS: s_axi_rdata <= status_w;
          SEL_GEOM_H: s_axi_rdata <= geom_h_q;
          SEL_GEOM_V: s_axi_rdata <= geom_v_q;
          SEL_FRAMES: s_axi_rdata <= {16'h0000, frames_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `XHV_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // pixel clock edge and video timing
  // ---------------------------------------------------------------
  reg pclk_d_q;
  reg [11:0] hcnt_q, vcnt_q;
  wire launch, h_last, v_last, in_active, frame_start, rd_start, rd_end;
  wire [11:0] h_total, h_act, v_total, v_act, h_end, v_end;
  assign h_total = geom_h_q[11:0];
  assign h_act = geom_h_q[27:16];
  assign v_total = geom_v_q[11:0];
  assign v_act = geom_v_q[27:16];
  assign h_end = h_act + `XHV_H_START;
  assign v_end = v_act + `XHV_V_START;
  assign h_last = (hcnt_q == h_total - 12'h001);
  assign v_last = (vcnt_q == v_total - 12'h001);
  // launch on the falling pixel clock edge as seen after the synchroniser, less than half a period before the rise
  assign launch = pclk_d_q & ~pclk_s & video_en;
  assign in_active = (hcnt_q >= `XHV_H_START) && (hcnt_q < h_end) &&
                     (vcnt_q >= `XHV_V_START) && (vcnt_q < v_end);
  assign frame_start = launch && (hcnt_q == 12'h000) && (vcnt_q == 12'h000);
  assign rd_start = launch && (hcnt_q == 12'h000) && (vcnt_q == `XHV_V_START);
  assign rd_end = launch && (hcnt_q == 12'h000) && (vcnt_q == v_end);
  // edge memory for the synchronised pixel clock
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pclk_d_q <= 1'b0;
    end else if (ce) begin
      pclk_d_q <= pclk_s;
    end
  end
  // pixel and line counters, reset to frame origin while video is off
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hcnt_q <= 12'h000;
      vcnt_q <= 12'h000;
    end else if (ce) begin
      if (!video_en) begin
        hcnt_q <= 12'h000;
        vcnt_q <= 12'h000;
      end else if (launch) begin
        if (h_last) begin
          hcnt_q <= 12'h000;
          vcnt_q <= v_last ? 12'h000 : vcnt_q + 12'h001;
        end else begin
          hcnt_q <= hcnt_q + 12'h001;
        end
      end
    end
  end
  // video outputs, updated at a launch point while video is on, idled at once while it is off
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frame_sync_n <= 1'b1;
      line_sync_n <= 1'b1;
      pixel_valid_n <= 1'b1;
      pixel_data <= 16'h0000;
      pixel_take <= 1'b0;
    end else if (ce) begin
      pixel_take <= launch & in_active;
      if (!video_en) begin
        frame_sync_n <= 1'b1;
        line_sync_n <= 1'b1;
        pixel_valid_n <= 1'b1;
        pixel_data <= 16'h0000;
      end else if (launch) begin
        // both syncs fall together at the frame origin
        frame_sync_n <= ~(vcnt_q < `XHV_VSYNC_W);
        line_sync_n <= ~(hcnt_q < `XHV_HSYNC_W);
        pixel_valid_n <= ~in_active;
        pixel_data <= in_active ? pixel_in : 16'h0000;
      end
    end
  end
  // frame counter for software
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frames_q <= 16'h0000;
    end else if (ce && frame_start) begin
      frames_q <= frames_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // exposure handshake
  // ---------------------------------------------------------------
  reg [31:0] health_cnt_q;
  reg [1:0] arm_frames_q;
  wire acq_active;
  // acquisition follows the request, gated by video_en
  assign acq_active = req_s & video_en;
  // startup delay before the detector reports healthy
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      health_cnt_q <= 32'h0000_0000;
      detector_ok_flag <= 1'b0;
    end else if (ce) begin
      if (health_cnt_q >= HEALTH_CYCLES - 32'h0000_0001) begin
        detector_ok_flag <= 1'b1;
      end else begin
        health_cnt_q <= health_cnt_q + 32'h0000_0001;
      end
    end
  end
  // arming at the first frame start after the request, timeout after three
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      detector_armed <= 1'b0;
      arm_frames_q <= 2'h0;
    end else if (ce) begin
      if (!req_s) begin
        detector_armed <= 1'b0;
        arm_frames_q <= 2'h0;
      end else if (frame_start && !detector_armed) begin
        if (detector_ok_flag) begin
          detector_armed <= 1'b1;
        end
        if (arm_frames_q != `XHV_ARM_FRAMES) begin
          arm_frames_q <= arm_frames_q + 2'h1;
        end
      end
    end
  end
  assign arm_err_set = ce && req_s && frame_start && !detector_armed && !detector_ok_flag &&
                       (arm_frames_q == `XHV_ARM_FRAMES - 2'h1);
  // sticky error, a new timeout wins over a clear by software
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arm_err_q <= 1'b0;
    end else if (arm_err_set) begin
      arm_err_q <= 1'b1;
    end else if (ce && wr_go && wr_sel == SEL_STATUS && wstrb_q[1] &&
                 wdata_q[`XHV_ST_ARM_ERR]) begin
      arm_err_q <= 1'b0;
    end
  end
  // permit and radiographic outputs
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      expose_ok_n <= 1'b1;
      rad_frame_shown <= 1'b0;
    end else if (ce) begin
      expose_ok_n <= ~(detector_armed & req_s & expose_en & detector_ok_flag);
      rad_frame_shown <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // exposure judgement
  // ---------------------------------------------------------------
  xhv_expo_eval u_eval (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .running(acq_active),
    .beam_ok(beam_s),
    .frame_start(frame_start),
    .rd_start(rd_start),
    .rd_end(rd_end),
    .frame_exposed_tag(frame_exposed_tag)
  );
endmodule // xhv_top
`default_nettype wire

// >>> rtl/xhv_consts.vh
// constants for the exposure handshake and video output block
`ifndef XHV_CONSTS_VH
`define XHV_CONSTS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define XHV_OFS_CTRL 12'h000
`define XHV_OFS_STATUS 12'h004
`define XHV_OFS_GEOM_H 12'h008
`define XHV_OFS_GEOM_V 12'h00c
`define XHV_OFS_FRAMES 12'h010
`define XHV_CTRL_VIDEO_EN 0
`define XHV_CTRL_EXPOSE_EN 1
`define XHV_CTRL_RST 2'h0
`define XHV_ST_ARM_ERR 8
`define XHV_GEOM_H_RST 32'h0529_0535
`define XHV_GEOM_V_RST 32'h0300_0320
`define XHV_RESP_OKAY 2'h0
`define XHV_RESP_SLVERR 2'h2

// ---------------------------------------------------------------
// video timing and arming timeout
// ---------------------------------------------------------------
`define XHV_HSYNC_W 12'h008
`define XHV_VSYNC_W 12'h002
`define XHV_H_START 12'h008
`define XHV_V_START 12'h007
`define XHV_ARM_FRAMES 2'h3

// ---------------------------------------------------------------
// time figures
// ---------------------------------------------------------------
`define XHV_CLK_HZ 25000000
`define XHV_HEALTH_TIME_S 30
`define XHV_HEALTH_CYCLES (`XHV_HEALTH_TIME_S * `XHV_CLK_HZ)

`endif

// >>> rtl/xhv_sync.v
// two-flop synchroniser bank for inputs from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module xhv_sync #(
  parameter W = 3
) (
  input wire clock,
  input wire arst_n,
  input wire ce,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  // one stage pair per bit, first stage read only by the second
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (ce) begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate
endmodule // xhv_sync
`default_nettype wire

// >>> rtl/xhv_expo_eval.v
// per-frame exposure judgement and exposure tag output
`timescale 1ns/1ns
`default_nettype none
module xhv_expo_eval (
  input wire clock,
  input wire arst_n,
  input wire ce,
  input wire running,
  input wire beam_ok,
  input wire frame_start,
  input wire rd_start,
  input wire rd_end,
  output reg frame_exposed_tag
);
  reg frm_acc_q;
  reg prev_ok_q;
  reg rd_acc_q;
  // frm_acc: beam held over the whole current frame period
  // prev_ok: beam held over the whole previous frame period
  // rd_acc: beam held over the readout of the current frame
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frm_acc_q <= 1'b0;
      prev_ok_q <= 1'b0;
      rd_acc_q <= 1'b0;
      frame_exposed_tag <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        frm_acc_q <= 1'b0;
        prev_ok_q <= 1'b0;
        rd_acc_q <= 1'b0;
        frame_exposed_tag <= 1'b0;
      end else begin
        if (frame_start) begin
          prev_ok_q <= frm_acc_q;
          frm_acc_q <= beam_ok;
        end else begin
          frm_acc_q <= frm_acc_q & beam_ok;
        end
        if (rd_start) begin
          rd_acc_q <= beam_ok;
        end else begin
          rd_acc_q <= rd_acc_q & beam_ok;
        end
        // while running, tag changes only at readout end, so it holds through vblank; it clears at once when running drops
        if (rd_end) begin
          frame_exposed_tag <= prev_ok_q & rd_acc_q & beam_ok;
        end
      end
    end
  end
endmodule // xhv_expo_eval
`default_nettype wire

// >>> tb/xhv_top_assertions.sv
// checker on the ports of the exposure handshake and video block
`timescale 1ns/1ns
`default_nettype none
module xhv_chk #(
  parameter [31:0] HEALTH_CYCLES = 32'd20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic pixel_clock,
  input wire logic detector_ok_flag,
  input wire logic detector_armed,
  input wire logic expose_ok_n,
  input wire logic frame_exposed_tag,
  input wire logic rad_frame_shown,
  input wire logic frame_sync_n,
  input wire logic line_sync_n,
  input wire logic pixel_valid_n,
  input wire logic [15:0] pixel_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [31:0] up_q;
  // cycles since reset, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) up_q <= 32'h0;
    else if (up_q != HEALTH_CYCLES + 32'h4) up_q <= up_q + 32'h1;
  end
  sequence line_start_s;
    $fell(line_sync_n);
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  health_time_a: assert property (up_q == HEALTH_CYCLES + 32'h4 |-> detector_ok_flag)
    else $error("health flag late");
  rad_idle_a: assert property (!rad_frame_shown)
    else $error("rad frame output active");
  permit_armed_a: assert property (!expose_ok_n |-> $past(detector_armed))
    else $error("permit without armed");
  armed_health_a: assert property (detector_armed |-> detector_ok_flag)
    else $error("armed while unhealthy");
  frame_line_a: assert property ($fell(frame_sync_n) |-> line_start_s)
    else $error("frame sync fell alone");
  tag_vblank_a: assert property ($rose(frame_exposed_tag) |-> line_start_s)
    else $error("tag rose off its update point");
  valid_area_a: assert property (!pixel_valid_n |-> line_sync_n && frame_sync_n)
    else $error("valid inside sync");
  data_blank_a: assert property (pixel_valid_n |-> pixel_data == 16'h0000)
    else $error("data outside valid area");
  launch_edge_a: assert property ($changed(line_sync_n) |-> !$past(pixel_clock))
    else $error("video changed in clock high phase");
endmodule // xhv_chk
bind xhv_top xhv_chk #(.HEALTH_CYCLES(HEALTH_CYCLES)) i_xhv_chk (
  .clock(clock), .arst_n(arst_n), .pixel_clock(pixel_clock),
  .detector_ok_flag(detector_ok_flag), .detector_armed(detector_armed),
  .expose_ok_n(expose_ok_n), .frame_exposed_tag(frame_exposed_tag),
  .rad_frame_shown(rad_frame_shown), .frame_sync_n(frame_sync_n),
  .line_sync_n(line_sync_n), .pixel_valid_n(pixel_valid_n), .pixel_data(pixel_data));
`default_nettype wire

// >>> tb/xhv_far_end.sv
// x-ray controller and frame grabber model
`timescale 1ns/1ns
`default_nettype none
module xhv_far_end (
  input wire logic clock,
  input wire logic want_req,
  input wire logic want_beam,
  input wire logic expose_ok_n,
  input wire logic pixel_take,
  input wire logic frame_sync_n,
  input wire logic pixel_valid_n,
  input wire logic [15:0] pixel_data,
  output logic pixel_clock,
  output logic expose_request,
  output logic beam_at_intensity,
  output logic [15:0] pixel_in,
  output logic [15:0] frames,
  output logic [15:0] last_pix,
  output logic [15:0] grab_err
);
  logic [15:0] pix_q;
  logic [15:0] exp_q;
  logic fs_q;
  logic seen_q;
  // free-running pixel clock, phase apart from clock
  initial begin
    {pix_q, exp_q, frames, last_pix, grab_err} = '0;
    {pixel_clock, expose_request, beam_at_intensity, seen_q} = '0;
    fs_q = 1'b1;
    pixel_in = 16'h1000;
    #7;
    forever #160 pixel_clock = ~pixel_clock;
  end
  // request and beam change with no relation to any clock
  always @(want_req) expose_request <= #9 want_req;
  always @(want_beam or expose_ok_n) beam_at_intensity <= #13 want_beam && !expose_ok_n;
  // next pixel value after each take
  always @(posedge clock) if (pixel_take) pixel_in <= pixel_in + 16'h1;
  // grabber samples on the pixel clock rise
  always @(posedge pixel_clock) begin
    fs_q <= frame_sync_n;
    if (fs_q && !frame_sync_n) begin
      frames <= frames + 16'h1;
      last_pix <= pix_q;
      pix_q <= 16'h0;
    end else if (!pixel_valid_n) begin
      pix_q <= pix_q + 16'h1;
      seen_q <= 1'b1;
      exp_q <= pixel_data + 16'h1;
      if (seen_q && pixel_data !== exp_q) grab_err <= grab_err + 16'h1;
    end
  end
endmodule // xhv_far_end
`default_nettype wire

// >>> tb/tb.sv
// testbench for the exposure handshake and video block
`timescale 1ns/1ns
`default_nettype none
`include "xhv_consts.vh"
module tb;
  localparam [31:0] HC = 32'd20;
  localparam [31:0] ACT_PIX = 32'd32; // 8 pixels by 4 lines
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pixel_take, pixel_clock, req, beam;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ok, armed, eok_n, tag, rad, fs_n, ls_n, pv_n;
  logic [15:0] pixel_in, pdata, frames, last_pix, grab_err;
  logic want_req = 1'b0, want_beam = 1'b0;
  int miscompares = 0, n_compared = 0, i;
  always #20 clock = ~clock;
  xhv_top #(.HEALTH_CYCLES(HC)) i_xhv_top (
    .clock(clock), .arst_n(arst_n), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixel_clock(pixel_clock), .beam_at_intensity(beam), .expose_request(req),
    .pixel_in(pixel_in), .pixel_take(pixel_take), .detector_ok_flag(ok),
    .detector_armed(armed), .expose_ok_n(eok_n), .frame_exposed_tag(tag),
    .rad_frame_shown(rad), .frame_sync_n(fs_n), .line_sync_n(ls_n),
    .pixel_valid_n(pv_n), .pixel_data(pdata));
  xhv_far_end i_xhv_far_end (
    .clock(clock), .want_req(want_req), .want_beam(want_beam), .expose_ok_n(eok_n),
    .pixel_take(pixel_take), .frame_sync_n(fs_n), .pixel_valid_n(pv_n),
    .pixel_data(pdata), .pixel_clock(pixel_clock), .expose_request(req),
    .beam_at_intensity(beam), .pixel_in(pixel_in), .frames(frames),
    .last_pix(last_pix), .grab_err(grab_err));
  // ------------------------------------------------------------
  // checks and closing report
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a wait that ran out counts a mismatch and ends the run
  task automatic expire;
    chk(32'h0, 32'h1);
    wrap_up();
  endtask
  // ------------------------------------------------------------
  // bus and frame tasks
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_hit, w_hit, b_hit;
    logic [1:0] r;
    n = 0;
    b_hit = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit) begin
      @(negedge clock);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid === 1'b1;
      r = bresp;
      n++;
      if (n > 100) expire();
      @(posedge clock);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar_hit, r_hit;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    r_hit = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit) begin
      @(negedge clock);
      ar_hit = arvalid && arready;
      r_hit = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      n++;
      if (n > 100) expire();
      @(posedge clock);
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // wait for the grabber to see the next frame start
  task automatic wait_frame;
    logic [15:0] f;
    int n;
    f = frames;
    n = 0;
    while (frames == f) begin
      @(posedge clock);
      n++;
      if (n > 3000) expire();
    end
    @(negedge clock);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    chk({25'h0, eok_n, armed, tag, rad, fs_n, ls_n, pv_n}, 32'h47);
    arst_n <= 1'b1;
    axi_rd(`XHV_OFS_CTRL, 32'h0, `XHV_RESP_OKAY);
    axi_rd(`XHV_OFS_GEOM_H, `XHV_GEOM_H_RST, `XHV_RESP_OKAY);
    axi_rd(`XHV_OFS_GEOM_V, `XHV_GEOM_V_RST, `XHV_RESP_OKAY);
    axi_rd(12'h020, 32'h0, `XHV_RESP_SLVERR);
    axi_wr(12'h020, 32'hffff_ffff, `XHV_RESP_SLVERR);
    for (i = 0; i < HC + 10 && ok !== 1'b1; i++) @(posedge clock);
    if (ok !== 1'b1) expire();
    axi_rd(`XHV_OFS_STATUS, 32'h1, `XHV_RESP_OKAY);
    axi_wr(`XHV_OFS_GEOM_H, 32'h0008_0014, `XHV_RESP_OKAY);
    axi_wr(`XHV_OFS_GEOM_V, 32'h0004_000e, `XHV_RESP_OKAY);
    axi_wr(`XHV_OFS_CTRL, 32'h3, `XHV_RESP_OKAY);
    axi_rd(`XHV_OFS_CTRL, 32'h3, `XHV_RESP_OKAY);
    wait_frame();
    wait_frame();
    chk({16'h0, last_pix}, ACT_PIX);
    want_req <= 1'b1;
    want_beam <= 1'b1;
    for (i = 0; i < 3 && armed !== 1'b1; i++) wait_frame();
    if (armed !== 1'b1) expire();
    repeat (2) @(posedge clock);
    chk({30'h0, armed, eok_n}, 32'h2);
    // beam follows the permit, so the arming frame is only partly exposed
    wait_frame();
    chk({31'h0, tag}, 32'h0);
    wait_frame();
    chk({31'h0, tag}, 32'h0);
    wait_frame();
    chk({31'h0, tag}, 32'h1);
    axi_rd(`XHV_OFS_STATUS, 32'h1f, `XHV_RESP_OKAY);
    axi_rd(`XHV_OFS_FRAMES, {16'h0, frames}, `XHV_RESP_OKAY);
    want_beam <= 1'b0;
    wait_frame();
    chk({30'h0, tag, armed}, 32'h1);
    want_beam <= 1'b1;
    wait_frame();
    chk({31'h0, tag}, 32'h0);
    wait_frame();
    chk({31'h0, tag}, 32'h0);
    wait_frame();
    chk({31'h0, tag}, 32'h1);
    chk({16'h0, grab_err}, 32'h0);
    chk({16'h0, last_pix}, ACT_PIX);
    want_req <= 1'b0;
    repeat (8) @(posedge clock);
    chk({30'h0, armed, eok_n}, 32'h1);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
